// file: design/sorc_routing_control.v
// output driver routing control register with axi4-lite slave
// Overview of operation
// - mode bit clear: first and second drivers run as independent single-ended outputs
// - mode bit set: first driver pairs with inverting earpiece driver differentially
// - differential without both drivers powered: both are powered down
// - first output dac field: 00 none, 01 left, 10 right, 11 average
// - sidetone bit routes sidetone to first output in either mode
// - buzzer bit routes buzzer stage to first output in either mode
// - keyclick bit routes keyclick to first output in either mode
// - phone input bit routes phone input to first output in either mode
// - second output dac field, same encoding, single-ended mode only
// - sidetone to second output, single-ended mode only
// - buzzer to second output, single-ended mode only
// - keyclick to second output, single-ended mode only
// - phone input to second output, single-ended mode only
// - first output mute bit, resets muted, applies in both modes
// - second output mute bit, resets muted
// - protection bit write-only: 0 enables, 1 disables; resets enabled
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "sorc_map.vh"
module sorc_routing_control
(
    input wire mclk,
    input wire reset_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg differentialMode,
    output reg firstDriverPower,
    output reg invertingDriverPower,
    output reg secondDriverPower,
    output reg firstDacLeft,
    output reg firstDacRight,
    output reg firstDacAverage,
    output reg [3:0] firstAnalogRoute,
    output reg secondDacLeft,
    output reg secondDacRight,
    output reg secondDacAverage,
    output reg [3:0] secondAnalogRoute,
    output reg firstOutputMute,
    output reg secondOutputMute,
    output reg headphoneProtectionDisable
);
    localparam [2:0] WR_IDLE = 3'b001;
    localparam [2:0] WR_HAVE = 3'b010;
    localparam [2:0] WR_RESP = 3'b100;

    reg [15:0] route_reg;
    reg [2:0] power_reg;
    reg [2:0] wrState_reg;
    reg [2:0] wrState_next;
    reg haveAddr_reg;
    reg haveData_reg;
    reg [7:0] wrAddr_reg;
    reg [31:0] wrData_reg;
    reg [3:0] wrStrb_reg;
    wire awTake;
    wire wTake;
    wire addrReady;
    wire dataReady;
    wire [7:0] curAddr;
    wire [31:0] curData;
    wire [3:0] curStrb;
    wire doWrite;
    wire diffSel;
    wire pairPowered;
    wire singleEnded;
    wire f1Left;
    wire f1Right;
    wire f1Avg;
    wire [3:0] f1Analog;
    wire f2Left;
    wire f2Right;
    wire f2Avg;
    wire [3:0] f2Analog;

    wire wrHitRoute;
    wire wrHitPower;
    wire rdHitRoute;
    wire rdHitPower;
    wire [15:0] route_next;
    wire [2:0] power_next;
    reg [31:0] readData_next;
    reg [1:0] readResp_next;
    // next values of the registered driver controls
    reg differentialMode_next;
    reg firstDriverPower_next;
    reg invertingDriverPower_next;
    reg secondDriverPower_next;
    reg firstDacLeft_next;
    reg firstDacRight_next;
    reg firstDacAverage_next;
    reg [3:0] firstAnalogRoute_next;
    reg secondDacLeft_next;
    reg secondDacRight_next;
    reg secondDacAverage_next;
    reg [3:0] secondAnalogRoute_next;
    reg firstOutputMute_next;
    reg secondOutputMute_next;
    reg headphoneProtectionDisable_next;

    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign addrReady = haveAddr_reg || awTake;
    assign dataReady = haveData_reg || wTake;
    assign curAddr = haveAddr_reg ? wrAddr_reg : s_axi_awaddr;
    assign curData = haveData_reg ? wrData_reg : s_axi_wdata;
    assign curStrb = haveData_reg ? wrStrb_reg : s_axi_wstrb;
    assign doWrite = (wrState_reg != WR_RESP) && addrReady && dataReady;

    // only the low address byte is decoded; the map's upper bits are zero
    assign wrHitRoute = ({24'h000000, curAddr} == `SORC_ROUTE_OFFSET);
    assign wrHitPower = ({24'h000000, curAddr} == `SORC_POWER_OFFSET);
    assign rdHitRoute = ({24'h000000, s_axi_araddr} == `SORC_ROUTE_OFFSET);
    assign rdHitPower = ({24'h000000, s_axi_araddr} == `SORC_POWER_OFFSET);

    genvar lane;
    // each byte lane of the routing register follows its own write strobe
    generate
        for (lane = 0; lane < 2; lane = lane + 1)
        begin : routeLane
            assign route_next[8 * lane +: 8] = (doWrite && wrHitRoute && curStrb[lane])
                ? curData[8 * lane +: 8] : route_reg[8 * lane +: 8];
        end
    endgenerate
    // power bits sit in the low lane only
    assign power_next = (doWrite && wrHitPower && curStrb[0]) ? curData[2:0] : power_reg;

    // read word built ahead of the flop; the write-only protection bit reads as zero
    always @*
    begin
        readData_next = 32'h0000_0000;
        readResp_next = `SORC_RESP_OKAY;
        if (rdHitRoute)
            readData_next = {16'h0000, route_reg[15:1], 1'b0};
        else if (rdHitPower)
            readData_next = {29'h0, power_reg};
        else
            readResp_next = `SORC_RESP_SLVERR;
    end

    always @*
    begin
        case (wrState_reg)
            WR_IDLE: wrState_next = doWrite ? WR_RESP : ((awTake || wTake) ? WR_HAVE : WR_IDLE);
            WR_HAVE: wrState_next = doWrite ? WR_RESP : WR_HAVE;
            WR_RESP: wrState_next = (s_axi_bready) ? WR_IDLE : WR_RESP;
            default: wrState_next = WR_IDLE;
        endcase
    end

    // address and data are taken in either order, then held until both are present
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrState_reg <= WR_IDLE;
            haveAddr_reg <= 1'b0;
            haveData_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            wrData_reg <= 32'h0000_0000;
            wrStrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SORC_RESP_OKAY;
            route_reg <= `SORC_ROUTE_RESET;
            power_reg <= `SORC_POWER_RESET;
        end
        else
        begin
            wrState_reg <= wrState_next;
            // both take their next value every cycle; it differs only on a write
            route_reg <= route_next;
            power_reg <= power_next;
            if (awTake && !doWrite)
            begin
                haveAddr_reg <= 1'b1;
                wrAddr_reg <= s_axi_awaddr;
            end
            if (wTake && !doWrite)
            begin
                haveData_reg <= 1'b1;
                wrData_reg <= s_axi_wdata;
                wrStrb_reg <= s_axi_wstrb;
            end
            // ready deasserted while a response is pending or a half is held
            s_axi_awready <= !(wrState_next == WR_RESP) && !(addrReady && !doWrite);
            s_axi_wready <= !(wrState_next == WR_RESP) && !(dataReady && !doWrite);
            if (doWrite)
            begin
                haveAddr_reg <= 1'b0;
                haveData_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SORC_RESP_OKAY;
                // unmapped writes store nothing and answer with an error
                if (!wrHitRoute && !wrHitPower)
                    s_axi_bresp <= `SORC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read channel: one read at a time, answer one cycle after address
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SORC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= readResp_next;
                s_axi_rdata <= readData_next;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    assign diffSel = route_reg[`SORC_BIT_DIFF];
    assign singleEnded = !diffSel;
    // software is expected to power both paired drivers; otherwise force them off
    assign pairPowered = power_reg[`SORC_BIT_PWR1] && power_reg[`SORC_BIT_PWRINV];

    sorc_output_route firstRoute
    (
        .dacSel(route_reg[`SORC_BIT_DAC1_HI:`SORC_BIT_DAC1_LO]),
        .analogEnable(route_reg[`SORC_BIT_AST1:`SORC_BIT_CPI1]),
        .routeAllowed(1'b1),
        .dacLeftOn(f1Left),
        .dacRightOn(f1Right),
        .dacAverageOn(f1Avg),
        .analogOn(f1Analog)
    );

    sorc_output_route secondRoute
    (
        .dacSel(route_reg[`SORC_BIT_DAC2_HI:`SORC_BIT_DAC2_LO]),
        .analogEnable(route_reg[`SORC_BIT_AST2:`SORC_BIT_CPI2]),
        .routeAllowed(singleEnded),
        .dacLeftOn(f2Left),
        .dacRightOn(f2Right),
        .dacAverageOn(f2Avg),
        .analogOn(f2Analog)
    );

    // next values of the driver controls, kept apart from the flops below
    always @*
    begin
        differentialMode_next = diffSel;
        firstDriverPower_next = power_reg[`SORC_BIT_PWR1];
        invertingDriverPower_next = 1'b0;
        secondDriverPower_next = power_reg[`SORC_BIT_PWR2];
        if (diffSel)
        begin
            // a half-powered pair would drive one leg alone, so both legs go off
            firstDriverPower_next = pairPowered;
            invertingDriverPower_next = pairPowered;
            secondDriverPower_next = 1'b0;
        end

        firstDacLeft_next = f1Left;
        firstDacRight_next = f1Right;
        firstDacAverage_next = f1Avg;
        firstAnalogRoute_next = f1Analog;
        secondDacLeft_next = f2Left;
        secondDacRight_next = f2Right;
        secondDacAverage_next = f2Avg;
        secondAnalogRoute_next = f2Analog;
        firstOutputMute_next = route_reg[`SORC_BIT_MUTE1];
        secondOutputMute_next = route_reg[`SORC_BIT_MUTE2];
        headphoneProtectionDisable_next = route_reg[`SORC_BIT_HPPROT];
    end

    // outputs registered so the analog side sees glitch-free controls
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            differentialMode <= 1'b0;
            firstDriverPower <= 1'b0;
            invertingDriverPower <= 1'b0;
            secondDriverPower <= 1'b0;
            firstDacLeft <= 1'b0;
            firstDacRight <= 1'b0;
            firstDacAverage <= 1'b0;
            firstAnalogRoute <= 4'h0;
            secondDacLeft <= 1'b0;
            secondDacRight <= 1'b0;
            secondDacAverage <= 1'b0;
            secondAnalogRoute <= 4'h0;
            firstOutputMute <= 1'b1;
            secondOutputMute <= 1'b1;
            headphoneProtectionDisable <= 1'b0;
        end
        else
        begin
            differentialMode <= differentialMode_next;
            firstDriverPower <= firstDriverPower_next;
            invertingDriverPower <= invertingDriverPower_next;
            secondDriverPower <= secondDriverPower_next;
            firstDacLeft <= firstDacLeft_next;
            firstDacRight <= firstDacRight_next;
            firstDacAverage <= firstDacAverage_next;
            firstAnalogRoute <= firstAnalogRoute_next;
            secondDacLeft <= secondDacLeft_next;
            secondDacRight <= secondDacRight_next;
            secondDacAverage <= secondDacAverage_next;
            secondAnalogRoute <= secondAnalogRoute_next;
            firstOutputMute <= firstOutputMute_next;
            secondOutputMute <= secondOutputMute_next;
            headphoneProtectionDisable <= headphoneProtectionDisable_next;
        end
    end
endmodule // sorc_routing_control
`default_nettype wire

// file: inc/sorc_map.vh
// register offsets, field positions and reset values of the output routing block
`ifndef SORC_MAP_VH
`define SORC_MAP_VH
`define SORC_ROUTE_OFFSET 32'h0000_0020
`define SORC_POWER_OFFSET 32'h0000_0024
`define SORC_BIT_DIFF 15
`define SORC_BIT_DAC1_HI 14
`define SORC_BIT_DAC1_LO 13
`define SORC_BIT_AST1 12
`define SORC_BIT_BUZ1 11
`define SORC_BIT_KCL1 10
`define SORC_BIT_CPI1 9
`define SORC_BIT_DAC2_HI 8
`define SORC_BIT_DAC2_LO 7
`define SORC_BIT_AST2 6
`define SORC_BIT_BUZ2 5
`define SORC_BIT_KCL2 4
`define SORC_BIT_CPI2 3
`define SORC_BIT_MUTE1 2
`define SORC_BIT_MUTE2 1
`define SORC_BIT_HPPROT 0
`define SORC_BIT_PWR1 0
`define SORC_BIT_PWRINV 1
`define SORC_BIT_PWR2 2
`define SORC_ROUTE_RESET 16'h0006
`define SORC_POWER_RESET 3'h0
`define SORC_DAC_NONE 2'h0
`define SORC_DAC_LEFT 2'h1
`define SORC_DAC_RIGHT 2'h2
`define SORC_DAC_AVG 2'h3
`define SORC_RESP_OKAY 2'h0
`define SORC_RESP_SLVERR 2'h2
`endif

// file: design/sorc_output_route.v
// per-output source combiner for one output driver
`timescale 1ns/1ns
`default_nettype none
`include "sorc_map.vh"
module sorc_output_route
(
    input wire [1:0] dacSel,
    input wire [3:0] analogEnable,
    input wire routeAllowed,
    output wire dacLeftOn,
    output wire dacRightOn,
    output wire dacAverageOn,
    output wire [3:0] analogOn
);
    // all selected sources are summed; none overrides another
    assign dacLeftOn = routeAllowed && (dacSel == `SORC_DAC_LEFT);
    assign dacRightOn = routeAllowed && (dacSel == `SORC_DAC_RIGHT);
    assign dacAverageOn = routeAllowed && (dacSel == `SORC_DAC_AVG);
    assign analogOn = routeAllowed ? analogEnable : 4'h0;
endmodule // sorc_output_route
`default_nettype wire

// file: test/sorc_routing_properties.sv
// checker properties for the output routing control block
`timescale 1ns/1ns
`default_nettype none
module sorc_routing_props
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic differentialMode,
    input wire logic firstDriverPower,
    input wire logic invertingDriverPower,
    input wire logic secondDriverPower,
    input wire logic firstDacLeft,
    input wire logic firstDacRight,
    input wire logic firstDacAverage,
    input wire logic secondDacLeft,
    input wire logic secondDacRight,
    input wire logic secondDacAverage,
    input wire logic [3:0] secondAnalogRoute,
    input wire logic firstOutputMute,
    input wire logic secondOutputMute,
    input wire logic headphoneProtectionDisable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (wrTake |=> s_axi_bvalid)
        else $error("write response missing");
    read_answer_a: assert property (rdTake |=> s_axi_rvalid)
        else $error("read response missing");
    second_gated_a: assert property (differentialMode |-> !secondDacLeft && !secondDacRight
        && !secondDacAverage && secondAnalogRoute == 4'h0) else $error("second output routed in differential");
    pair_power_a: assert property (differentialMode |-> firstDriverPower == invertingDriverPower)
        else $error("paired driver power differs");
    second_off_a: assert property (differentialMode |-> !secondDriverPower)
        else $error("second driver on in differential");
    single_inv_off_a: assert property (!differentialMode |-> !invertingDriverPower)
        else $error("inverting driver on in single-ended");
    dac_onehot_a: assert property ($onehot0({firstDacLeft, firstDacRight, firstDacAverage}))
        else $error("first dac select not one-hot");
    reset_muted_a: assert property ($rose(reset_n) |-> firstOutputMute && secondOutputMute
        && !headphoneProtectionDisable) else $error("wrong state after reset");
    mode_update_a: assert property ($changed(differentialMode) |-> $past(s_axi_bvalid))
        else $error("mode changed without a write");
endmodule // sorc_routing_props
bind sorc_routing_control sorc_routing_props chk (.*);
`default_nettype wire

// file: test/sorc_routing_control_tb.sv
// self-checking bench for the output routing control block
`timescale 1ns/1ns
`default_nettype none
`include "sorc_map.vh"
module sorc_routing_control_tb;
    localparam logic [7:0] RT = 8'(`SORC_ROUTE_OFFSET);
    localparam logic [7:0] PW = 8'(`SORC_POWER_OFFSET);
    logic mclk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
    logic [3:0] s_axi_wstrb, firstAnalogRoute, secondAnalogRoute;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic differentialMode, firstDriverPower, invertingDriverPower, secondDriverPower;
    logic firstDacLeft, firstDacRight, firstDacAverage, secondDacLeft, secondDacRight;
    logic secondDacAverage, firstOutputMute, secondOutputMute, headphoneProtectionDisable;
    logic [54:0] rdNotes[$];
    logic [1:0] wrNotes[$];
    logic [15:0] routeVal;
    logic [2:0] powerVal;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    sorc_routing_control dut (.*);
    wire [20:0] outs = {differentialMode, firstDriverPower, invertingDriverPower, secondDriverPower,
        firstDacLeft, firstDacRight, firstDacAverage, firstAnalogRoute, secondDacLeft,
        secondDacRight, secondDacAverage, secondAnalogRoute, firstOutputMute,
        secondOutputMute, headphoneProtectionDisable};
    // differential drops second-output routes and keeps paired power only when both are on
    function automatic logic [20:0] mdl(input logic [15:0] r, input logic [2:0] p);
        logic d;
        d = r[15];
        return {d, d ? {p[0] & p[1], p[0] & p[1], 1'b0} : {p[0], 1'b0, p[2]},
            r[14:13] == 2'h1, r[14:13] == 2'h2, r[14:13] == 2'h3, r[12:9],
            {r[8:7] == 2'h1, r[8:7] == 2'h2, r[8:7] == 2'h3, r[6:3]} & {7{!d}}, r[2:0]};
    endfunction
    task automatic cmp(input string nm, input logic [54:0] e, input logic [54:0] s);
        n_compared++;
        if (e !== s)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
        input logic [1:0] er);
        bit ad;
        bit dd;
        ad = 0;
        dd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        wrNotes.push_back(er);
        while (!(ad && dd))
        begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1 && !ad) begin s_axi_awvalid <= 1'b0; ad = 1; end
            if (s_axi_wready === 1'b1 && !dd) begin s_axi_wvalid <= 1'b0; dd = 1; end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        logic [31:0] ed;
        ed = (a == RT) ? {16'h0, routeVal & 16'hfffe} : (a == PW) ? {29'h0, powerVal} : 32'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rdNotes.push_back({er, ed, mdl(routeVal, powerVal)});
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    endtask
    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        routeVal = `SORC_ROUTE_RESET;
        powerVal = `SORC_POWER_RESET;
        rd(RT, `SORC_RESP_OKAY);
        rd(PW, `SORC_RESP_OKAY);
    endtask
    task test_done;
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready)
            cmp("read", rdNotes.pop_front(), {s_axi_rresp, s_axi_rdata, outs});
        if (s_axi_bvalid === 1'b1 && s_axi_bready)
            cmp("bresp", {53'h0, wrNotes.pop_front()}, {53'h0, s_axi_bresp});
        cycles++;
        // well above the ~180 cycles the sequence needs
        if (cycles == 3000)
        begin
            n_mismatch++;
            test_done;
        end
    end
    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        reset_n = 1'b0;
        rnd = $urandom(32'h3b3b7041);
        do_reset;
        for (int i = 0; i < 16; i++)
        begin
            rnd = $urandom;
            powerVal = (i < 8) ? 3'h7 : rnd[18:16];
            routeVal = {i[0], i[2:1], rnd[12:9], i[2:1], rnd[6:0]};
            wr(PW, {13'h0, powerVal}, 4'hf, `SORC_RESP_OKAY);
            wr(RT, routeVal, 4'hf, `SORC_RESP_OKAY);
            rd(RT, `SORC_RESP_OKAY);
            rd(PW, `SORC_RESP_OKAY);
        end
        wr(RT, 16'ha5ff, 4'h2, `SORC_RESP_OKAY);
        routeVal[15:8] = 8'ha5;
        rd(RT, `SORC_RESP_OKAY);
        wr(8'h28, 16'hffff, 4'hf, `SORC_RESP_SLVERR);
        rd(8'h30, `SORC_RESP_SLVERR);
        rd(RT, `SORC_RESP_OKAY);
        do_reset;
        repeat (2) @(posedge mclk);
        test_done;
    end
endmodule // sorc_routing_control_tb
`default_nettype wire
